// ===== shared/ext_int_pkg.sv
// constants, types and field layout for the external interrupt sense block
// assumes a single clock and a plain address/strobe register port
//
// Contract
// - pin b sense field bits 3:2: 00 low, 01 change, 10 fall, 11 rise
// - pin a sense field bits 1:0: 00 low, 01 change, 10 fall, 11 rise
// - pin b request raised only with global enable and its mask set; irq output ignores both, gated by its irq mask only
// - pin a request raised only with global enable and its mask set; irq output ignores both, gated by its irq mask only
// - pins sampled into registers; edges compare successive samples only
// - edge or change pulses longer than one clock give a request
// - control bits 7:4 read zero; writes to them ignored
// - low level request only while the low level persists
// - edge flag stays set until serviced or cleared by software
package ext_int_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] addr_sense_control = 4'h0;
  localparam logic [3:0] addr_mask          = 4'h1;
  localparam logic [3:0] addr_flags         = 4'h2;
  localparam logic [3:0] addr_global        = 4'h3;
  localparam logic [3:0] addr_status        = 4'h4;
  localparam logic [3:0] addr_irq_mask      = 4'h5;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          pin_a_sense_pos  = 0;
  localparam int          pin_b_sense_pos  = 2;
  localparam logic [3:0]  sense_used_mask  = 4'h0f;
  localparam logic [7:0]  sense_reset      = 8'h00;
  localparam logic [1:0]  mask_reset       = 2'h0;
  localparam logic [1:0]  irq_mask_reset   = 2'h0;

  typedef enum logic [1:0] {
    sense_low    = 2'b00,
    sense_change = 2'b01,
    sense_fall   = 2'b10,
    sense_rise   = 2'b11
  } sense_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

endpackage

// ===== logic/pin_sense.sv
// one pin's sampler, edge detector and flag
// assumes pin is synchronous to clk
`timescale 1ns/10ps
module pin_sense (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // pin and mode
  input  wire logic                pin,
  input  wire ext_int_pkg::sense_t mode,
  // flag control
  input  wire logic                flag_clr,
  output logic                     req
);

  logic samp_reg;
  logic prev_reg;
  logic flag_reg;
  logic edge_hit;
  logic level_hit;

  // prev always tracks samp, independent of mode, so mode changes add nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      samp_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      samp_reg <= pin;
      prev_reg <= samp_reg;
    end
  end

  always_comb begin
    edge_hit = 1'b0;
    case (mode)
      ext_int_pkg::sense_change: edge_hit = samp_reg ^ prev_reg;
      ext_int_pkg::sense_fall:   edge_hit = prev_reg & ~samp_reg;
      ext_int_pkg::sense_rise:   edge_hit = ~prev_reg & samp_reg;
      default:                   edge_hit = 1'b0;
    endcase
  end

  assign level_hit = (mode == ext_int_pkg::sense_low) & ~samp_reg;

  // set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= edge_hit | (flag_reg & ~flag_clr);
    end
  end

  assign req = level_hit | flag_reg;

endmodule

// ===== logic/ext_int_sense.sv
// external interrupt sense control for two pins with register port
// assumes synchronous pins and a one-cycle strobe master
`timescale 1ns/10ps
module ext_int_sense (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // register port
  input  wire logic [3:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  // pins
  input  wire logic                 ext_irq_pin_a,
  input  wire logic                 ext_irq_pin_b,
  // core side
  input  wire logic                 core_global_ie,
  input  wire logic [1:0]           irq_ack,
  output logic      [1:0]           core_req,
  output logic                      irq
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [3:0] sense_reg;
  logic [1:0] mask_reg;
  logic       gie_reg;
  logic [1:0] status_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] raw_req;
  logic [1:0] prev_req;
  logic [1:0] flag_clr;
  logic [1:0] core_req_next;
  logic [7:0] rdata_next;
  logic       wr_sense;
  logic       wr_mask;
  logic       wr_flags;
  logic       wr_global;
  logic       wr_irq_mask;
  logic       rd_status;
  logic [1:0] status_next;

  assign wr_sense    = wr & (addr == ext_int_pkg::addr_sense_control);
  assign wr_mask     = wr & (addr == ext_int_pkg::addr_mask);
  assign wr_flags    = wr & (addr == ext_int_pkg::addr_flags);
  assign wr_global   = wr & (addr == ext_int_pkg::addr_global);
  assign wr_irq_mask = wr & (addr == ext_int_pkg::addr_irq_mask);
  assign rd_status   = rd & (addr == ext_int_pkg::addr_status);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sense_reg    <= ext_int_pkg::sense_reset[3:0];
      mask_reg     <= ext_int_pkg::mask_reset;
      gie_reg      <= 1'b0;
      irq_mask_reg <= ext_int_pkg::irq_mask_reset;
    end else begin
      if (wr_sense)    sense_reg    <= wdata[3:0] & ext_int_pkg::sense_used_mask;
      if (wr_mask)     mask_reg     <= wdata[1:0];
      if (wr_global)   gie_reg      <= wdata[0];
      if (wr_irq_mask) irq_mask_reg <= wdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // per pin sensing
  // ---------------------------------------------------------------
  // software clears with a one written, the core clears on acknowledge
  assign flag_clr = (wr_flags ? wdata[1:0] : 2'h0) | irq_ack;

  pin_sense u_pin_a (
    .clk      (clk),
    .nrst     (nrst),
    .pin      (ext_irq_pin_a),
    .mode     (ext_int_pkg::sense_t'(sense_reg[ext_int_pkg::pin_a_sense_pos +: 2])),
    .flag_clr (flag_clr[0]),
    .req      (raw_req[0])
  );

  pin_sense u_pin_b (
    .clk      (clk),
    .nrst     (nrst),
    .pin      (ext_irq_pin_b),
    .mode     (ext_int_pkg::sense_t'(sense_reg[ext_int_pkg::pin_b_sense_pos +: 2])),
    .flag_clr (flag_clr[1]),
    .req      (raw_req[1])
  );

  // ---------------------------------------------------------------
  // core request and software interrupt status
  // ---------------------------------------------------------------
  // either the register bit or the core input may enable globally
  assign core_req_next[0] = raw_req[0] & mask_reg[0] & (gie_reg | core_global_ie);
  assign core_req_next[1] = raw_req[1] & mask_reg[1] & (gie_reg | core_global_ie);

  // status bit set on rising raw request; set wins over read clear
  assign status_next = (raw_req & ~prev_req) | (status_reg & {2{~rd_status}});

  assign rdata_next = rd_status                                      ? {6'h00, status_reg} :
                      (rd & addr == ext_int_pkg::addr_sense_control) ? {4'h0, sense_reg} :
                      (rd & addr == ext_int_pkg::addr_mask)          ? {6'h00, mask_reg} :
                      (rd & addr == ext_int_pkg::addr_flags)         ? {6'h00, raw_req} :
                      (rd & addr == ext_int_pkg::addr_global)        ? {7'h00, gie_reg} :
                      (rd & addr == ext_int_pkg::addr_irq_mask)      ? {6'h00, irq_mask_reg} :
                                                                       8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_req   <= 2'h0;
      status_reg <= 2'h0;
      core_req   <= 2'h0;
      irq        <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      prev_req   <= raw_req;
      status_reg <= status_next;
      core_req   <= core_req_next;
      irq        <= |(status_next & irq_mask_reg);
      rdata      <= rdata_next;
    end
  end

endmodule

// ===== sim/ext_int_sense_properties.sv
// port checker for ext_int_sense
// assumes written registers can be shadowed from the port
`timescale 1ns/10ps
module ext_int_sense_properties (
  // clock, reset, register port
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // pins and core side
  input wire logic       ext_irq_pin_a,
  input wire logic       ext_irq_pin_b,
  input wire logic       core_global_ie,
  input wire logic [1:0] irq_ack,
  input wire logic [1:0] core_req,
  input wire logic       irq
);
  logic [3:0] sense_reg;
  logic [1:0] mask_reg;
  logic       glob_reg;
  wire  [1:0] en      = mask_reg & {2{glob_reg | core_global_ie}};
  wire        clr     = irq_ack[0] | (wr & addr == 4'h2 & wdata[0]);
  wire        clr_b   = irq_ack[1] | (wr & addr == 4'h2 & wdata[1]);
  wire        rd_ctrl = rd & (addr == 4'h0);
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) begin
      sense_reg <= 4'h0;
      mask_reg  <= 2'h0;
      glob_reg  <= 1'b0;
    end else if (wr) begin
      if (addr == 4'h0) sense_reg <= wdata[3:0];
      if (addr == 4'h1) mask_reg <= wdata[1:0];
      if (addr == 4'h3) glob_reg <= wdata[0];
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_sense_read:
    assert property ($past(rd_ctrl) |-> rdata == {4'h0, $past(sense_reg)}) else $error("sense read");
  a_gate_pin_a:
    assert property (core_req[0] |-> $past(en[0])) else $error("pin a ungated");
  a_gate_pin_b:
    assert property (core_req[1] |-> $past(en[1])) else $error("pin b ungated");
  a_level_on:
    assert property ((sense_reg[1:0] == 2'b00 && !ext_irq_pin_a && en[0]) [*4] |-> core_req[0]) else $error("no level");
  // a flag left from an edge mode may legally survive a switch to low level, so start from a clear
  a_level_off:
    assert property ((clr && sense_reg[1:0] == 2'b00) ##1 (sense_reg[1:0] == 2'b00 && ext_irq_pin_a) [*4]
      |-> !core_req[0]) else $error("level kept");
  a_rise_pin_a:
    assert property (sense_reg[1:0] == 2'b11 && $rose(ext_irq_pin_a) ##0 (en[0] && !clr) [*6] |-> core_req[0])
      else $error("rise lost");
  a_fall_pin_b:
    assert property (sense_reg[3:2] == 2'b10 && $fell(ext_irq_pin_b) ##0 (en[1] && !clr_b) [*6] |-> core_req[1])
      else $error("fall lost");
  a_flag_kept:
    assert property (core_req[0] && en[0] && sense_reg[1:0] != 2'b00 && $stable(sense_reg) && !$past(clr) |=> core_req[0])
      else $error("flag lost");
endmodule
bind ext_int_sense ext_int_sense_properties u_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
  .core_global_ie(core_global_ie), .irq_ack(irq_ack), .core_req(core_req), .irq(irq));

// ===== sim/pin_source.sv
// model of the two sources that drive the interrupt pins
// assumes the bench sets the wanted levels; pins move after clk
`timescale 1ns/10ps
module pin_source (
  // clock and wanted levels, bit0 pin a
  input  wire logic       clk,
  input  wire logic [1:0] level,
  // pins, idle high
  output logic            pin_a = 1'b1,
  output logic            pin_b = 1'b1
);
  // a low level stays until the bench lifts it
  always @(posedge clk) begin
    pin_a <= level[0];
    pin_b <= level[1];
  end
endmodule

// ===== sim/ext_int_sense_test.sv
// self-checking bench for ext_int_sense
// assumes pin_source and the bound port checker
`timescale 1ns/10ps
module ext_int_sense_test;
  logic                  clk;
  logic                  nrst        = 1'b0;
  ext_int_pkg::bus_req_t req         = '0;
  logic [1:0]            lvl         = 2'b11;
  logic                  gie         = 1'b0;
  logic [1:0]            ack         = 2'b00;
  logic                  pin_a;
  logic                  pin_b;
  logic [7:0]            rdata;
  logic [1:0]            core_req;
  logic                  irq;
  int                    fail_count  = 0;
  int                    comparisons = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  pin_source src (.clk(clk), .level(lvl), .pin_a(pin_a), .pin_b(pin_b));
  ext_int_sense DUT (.clk(clk), .nrst(nrst), .addr(req.addr), .wdata(req.wdata), .wr(req.wr), .rd(req.rd),
    .rdata(rdata), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .core_global_ie(gie), .irq_ack(ack),
    .core_req(core_req), .irq(irq));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask
  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(4'h0, 8'h00);
    wr_reg(4'h0, 8'hff);
    rd_reg(4'h0, 8'h0f);
    wr_reg(4'h1, 8'h03);
    @(posedge clk) gie <= 1'b1;
    // every sense code on each pin: steady, falling, then rising
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++) begin
        wr_reg(4'h0, 8'(m << (2 * p)));
        wr_reg(4'h2, 8'h03);
        tick(6);
        chk("core_req", 8'h00, {6'h00, core_req});
        lvl[p] <= 1'b0;
        tick(6);
        chk("core_req", 8'(m != 3) << p, {6'h00, core_req});
        wr_reg(4'h2, 8'h03);
        lvl[p] <= 1'b1;
        tick(6);
        chk("core_req", 8'(m % 2) << p, {6'h00, core_req});
      end
    // events while gated are held until enabled
    wr_reg(4'h0, 8'h02);
    wr_reg(4'h2, 8'h03);
    wr_reg(4'h1, 8'h00);
    @(posedge clk) gie <= 1'b0;
    lvl <= 2'b00;
    tick(6);
    chk("core_req", 8'h00, {6'h00, core_req});
    rd_reg(4'h2, 8'h03);
    wr_reg(4'h1, 8'h03);
    tick(4);
    chk("core_req", 8'h00, {6'h00, core_req});
    wr_reg(4'h3, 8'h01);
    tick(4);
    chk("core_req", 8'h03, {6'h00, core_req});
    @(posedge clk) ack <= 2'b01;
    @(posedge clk) ack <= 2'b00;
    tick(4);
    chk("core_req", 8'h02, {6'h00, core_req});
    // status, irq mask and an unmapped address
    chk("irq", 8'h00, {7'h00, irq});
    wr_reg(4'h5, 8'h03);
    tick(2);
    chk("irq", 8'h01, {7'h00, irq});
    rd_reg(4'h4, 8'h03);
    tick(2);
    chk("irq", 8'h00, {7'h00, irq});
    rd_reg(4'h1, 8'h03);
    rd_reg(4'h3, 8'h01);
    rd_reg(4'h5, 8'h03);
    wr_reg(4'hf, 8'hff);
    rd_reg(4'hf, 8'h00);
    test_done;
  end
endmodule
